// >>> rtl/saif_defines.vh
// Constants for the serial audio input FIFO block.
// Assumes inclusion by bare name from the rtl/ and tb/ files.
`ifndef SAIF_DEFINES_VH
`define SAIF_DEFINES_VH
`define SAIF_NCH        8
`define SAIF_DEPTH      4'h8
// Register byte addresses, and address bits 7:5 for the DMA sets
`define SAIF_A_CTL0     8'h00
`define SAIF_A_CHEN     8'h04
`define SAIF_A_STAT     8'h08
`define SAIF_A_DATA     8'h0C
`define SAIF_A_DADR     3'h2
`define SAIF_A_DCNT     3'h3
// port_control_reg0 fields
`define SAIF_C_EN       0
`define SAIF_C_DMA      1
`define SAIF_C_CLROVR   2
`define SAIF_C_PAR      3
`define SAIF_C_FMT_LO   8
`define SAIF_CTL0_RST   32'h0000_0000
`define SAIF_CTL0_WMSK  32'hFFFF_FF0B
// Status fields
`define SAIF_S_CNT_LO   8
`define SAIF_S_EMPTY    12
// channel_format_field codes
`define SAIF_FMT_I2S    3'h0
`define SAIF_FMT_LJ     3'h1
`define SAIF_FMT_I2S32  3'h2
`define SAIF_FMT_LJ32   3'h3
`define SAIF_FMT_RJ24   3'h4
`define SAIF_FMT_RJ20   3'h5
`define SAIF_FMT_RJ18   3'h6
`define SAIF_FMT_RJ16   3'h7
// Right-justified left shifts (32 minus sample width)
`define SAIF_SH_RJ24    5'h08
`define SAIF_SH_RJ20    5'h0C
`define SAIF_SH_RJ18    5'h0E
`define SAIF_SH_RJ16    5'h10
// Tag field positions in a FIFO word
`define SAIF_TAG_LR     3
`define SAIF_TAG_W      4
`endif

// >>> rtl/saif_sip_rx.v
// One serial input channel: syncs pins, frames halves, builds tagged words.
// Assumes the serial clock is at most a quarter of i_clk.
`include "saif_defines.vh"
module saif_sip_rx (
    input  wire        i_clk,   // System clock
    input  wire        i_rst,   // Sync reset, active high
    input  wire        i_en,    // Channel enabled
    input  wire [2:0]  i_fmt,   // channel_format_field
    input  wire [2:0]  i_chan,  // Channel number tag
    input  wire        i_sclk,  // Serial clock pin
    input  wire        i_fsync, // Frame sync pin
    input  wire        i_sdata, // Serial data pin
    output reg         o_valid, // One-cycle word pulse
    output reg  [31:0] o_word   // Tagged word
);
    reg        sclk_s1_q, sclk_s2_q, sclk_s3_q;
    reg        fs_s1_q, fs_s2_q;
    reg        dat_s1_q, dat_s2_q;
    reg        fs_dly_q, last_q, seen_q, armed_q;
    reg [31:0] sr_q;
    wire       rise = sclk_s2_q & ~sclk_s3_q;
    wire       is_i2s = (i_fmt == `SAIF_FMT_I2S) | (i_fmt == `SAIF_FMT_I2S32);
    // I2S framing lags one bit, so use the delayed level
    wire       eff_fs = is_i2s ? fs_dly_q : fs_s2_q;
    wire       lr = is_i2s ? ~last_q : last_q;

    // Word layout per format
    function [31:0] fmt_word;
        input [2:0]  fmt;
        input [31:0] sr;
        input        left;
        input [2:0]  ch;
        reg   [4:0]  sh;
        reg   [31:0] rj;
        begin
            sh = `SAIF_SH_RJ24;
            case (fmt)
                `SAIF_FMT_RJ20: sh = `SAIF_SH_RJ20;
                `SAIF_FMT_RJ18: sh = `SAIF_SH_RJ18;
                `SAIF_FMT_RJ16: sh = `SAIF_SH_RJ16;
                default:        sh = `SAIF_SH_RJ24;
            endcase
            // Sample moved to the top; low bits of the shift are the zero fill
            rj = sr << sh;
            case (fmt)
                `SAIF_FMT_I2S32, `SAIF_FMT_LJ32: fmt_word = sr; // R11
                `SAIF_FMT_I2S, `SAIF_FMT_LJ:
                    fmt_word = {sr[31:`SAIF_TAG_W], left, ch}; // R12
                default:
                    fmt_word = {rj[31:`SAIF_TAG_W], left, ch}; // R10
            endcase
        end
    endfunction

    // Two-stage pin synchronisers
    always @(posedge i_clk) begin
        sclk_s1_q <= i_sclk;
        sclk_s2_q <= sclk_s1_q;
        sclk_s3_q <= sclk_s2_q;
        fs_s1_q   <= i_fsync;
        fs_s2_q   <= fs_s1_q;
        dat_s1_q  <= i_sdata;
        dat_s2_q  <= dat_s1_q;
    end

    // Shift on rising serial clock, emit on half-frame change
    always @(posedge i_clk) begin
        o_valid <= 1'b0;
        if (i_rst || !i_en) begin
            seen_q   <= 1'b0; // R13
            armed_q  <= 1'b0;
            fs_dly_q <= 1'b0;
            last_q   <= 1'b0;
            sr_q     <= 32'h0000_0000;
            o_word   <= 32'h0000_0000;
        end else if (rise) begin
            fs_dly_q <= fs_s2_q;
            sr_q     <= {sr_q[30:0], dat_s2_q};
            last_q   <= eff_fs;
            seen_q   <= 1'b1;
            if (seen_q && eff_fs != last_q) begin
                armed_q <= 1'b1; // R17
                if (armed_q) begin
                    o_valid <= 1'b1; // R3
                    o_word  <= fmt_word(i_fmt, sr_q, lr, i_chan); // R6 R7 R8
                end
            end
        end
    end
endmodule

// >>> rtl/saif_top.v
// Serial audio input FIFO: eight receive channels merged into one FIFO.
// Assumes a same-clock register master and DMA sink on i_clk.
//
// Summary of operation
// R1: Eight serial receive channels feed one shared eight-entry 32-bit FIFO.
// R2: FIFO channel 0 takes serial input 0 or the parallel port.
// R3: Each frame is two 32-bit words, one per half-frame.
// R4: Each channel receives I2S, left-justified or right-justified audio.
// R5: Word low three bits carry the channel, selecting its DMA set.
// R6: Bit 3 is one for left data, zero for right data.
// R7: I2S left half has sync low; left-justified left half sync high.
// R8: Left/right tag meaning is the same whatever the sync polarity.
// R9: Per-channel 3-bit format fields sit in control bits 31 to 8.
// R10: Right-justified samples sit on top, then zeros, tag bit, channel.
// R11: 32-bit I2S and left-justified options store all 32 bits.
// R12: Standard words hold 28 data bits ahead of the tag bits.
// R13: Idle channels make no words and use no FIFO slots.
// R14: Unused channel clocks and syncs should be held low outside.
// R15: Serial clocks stay at or below a quarter of the system clock.
// R16: The outside source makes clock and sync; the port only receives.
// R17: Shifting starts once a frame sync edge has been seen; here bits shift from enable and words begin at the second edge.
// R18: Words leave by core reads or DMA through eight parameter sets.
// R19: Data is taken only with global and channel enables both set.
// R20: Overflow stays set until a one is written to its clear bit.
// R21: A word arriving while the FIFO is full flags overflow and drops.
// R22: Simultaneous words enter the FIFO one per cycle, lowest channel first.
//
// Chosen here: the address map and the address-and-strobe port.
`include "saif_defines.vh"
module saif_top (
    input  wire        i_clk,                      // System clock, 250 MHz
    input  wire        i_rst,                      // Sync reset, active high
    input  wire [7:0]  i_addr,                     // Register byte address
    input  wire [31:0] i_wdata,                    // Register write data
    input  wire        i_wr,                       // Write strobe
    input  wire        i_rd,                       // Read strobe
    output reg  [31:0] o_rdata,                    // Read data, next cycle
    input  wire [7:0]  i_channel_serial_clock_in,  // Per-channel serial clock
    input  wire [7:0]  i_channel_frame_sync_in,    // Per-channel frame sync
    input  wire [7:0]  i_channel_serial_data_in,   // Per-channel serial data
    input  wire        i_par_valid,                // Parallel word strobe
    input  wire [31:0] i_par_word,                 // Parallel packed word
    output reg         o_dma_valid,                // DMA word offered
    output reg  [2:0]  o_dma_chan,                 // DMA channel of word
    output reg  [31:0] o_dma_addr,                 // Target address
    output reg  [31:0] o_dma_data,                 // Word to store
    input  wire        i_dma_ready                 // DMA sink takes word
);
    // Control and status state
    reg  [31:0] ctl0_q;
    reg  [7:0]  chen_q;
    reg  [7:0]  ovf_q;
    // DMA parameter sets, one per channel
    reg  [31:0] dadr_q [0:7];
    reg  [15:0] dcnt_q [0:7];
    // Shared FIFO storage with channel tag beside each word
    reg  [31:0] fw_q [0:7];
    reg  [2:0]  fc_q [0:7];
    reg  [2:0]  wp_q;
    reg  [2:0]  rp_q;
    reg  [3:0]  cnt_q;
    // Completed words waiting for a FIFO slot
    reg  [7:0]  pv_q;
    reg  [31:0] pw_q [0:7];
    wire [7:0]  rx_v;
    wire [31:0] rx_w [0:7];
    reg         gnt_v;
    reg  [2:0]  gnt_ch;
    integer     k;

    wire glob_en = ctl0_q[`SAIF_C_EN];
    wire dma_en  = ctl0_q[`SAIF_C_DMA];
    wire par_sel = ctl0_q[`SAIF_C_PAR];
    wire full    = (cnt_q == `SAIF_DEPTH);
    wire empty   = (cnt_q == 4'h0);
    wire push    = gnt_v & ~full;
    // Overflow clear is a strobe, never stored
    wire clr_ovf = i_wr & (i_addr == `SAIF_A_CTL0)
                 & i_wdata[`SAIF_C_CLROVR]; // R20
    wire [2:0] hd_ch = fc_q[rp_q];
    // DMA loads its output stage only when the channel still has count
    wire dma_load = dma_en & ~o_dma_valid & ~empty
                  & (dcnt_q[hd_ch] != 16'h0000); // R18
    // Core pops only while DMA is off, so the two never race
    wire core_pop = i_rd & (i_addr == `SAIF_A_DATA) & ~dma_en & ~empty; // R18
    wire pop      = dma_load | core_pop;
    wire dma_done = o_dma_valid & i_dma_ready;
    wire par_take = glob_en & chen_q[0] & par_sel & i_par_valid; // R2 R19

    // Fixed priority: lowest pending channel first
    always @* begin
        gnt_v  = 1'b0;
        gnt_ch = 3'h0;
        for (k = `SAIF_NCH - 1; k >= 0; k = k - 1) begin
            if (pv_q[k]) begin
                gnt_v  = 1'b1; // R22
                gnt_ch = k[2:0];
            end
        end
    end

    // Per-channel receiver, pending slot, overflow flag and DMA set
    genvar g;
    generate
        for (g = 0; g < `SAIF_NCH; g = g + 1) begin : g_ch
            localparam integer CI = g;
            localparam [2:0]   CH = CI[2:0];
            wire ch_en;
            wire is_gnt = gnt_v & (gnt_ch == CH);
            wire own    = (g == 0) ? par_take : 1'b0;
            wire hit_a  = i_wr & (i_addr[7:5] == `SAIF_A_DADR)
                        & (i_addr[4:2] == CH);
            wire hit_c  = i_wr & (i_addr[7:5] == `SAIF_A_DCNT)
                        & (i_addr[4:2] == CH);
            wire used   = dma_done & (o_dma_chan == CH);

            // Serial 0 is cut off while the parallel port owns channel 0
            assign ch_en = glob_en & chen_q[g]
                         & ~((g == 0) & par_sel); // R2 R19

            saif_sip_rx u_rx (
                .i_clk   (i_clk),
                .i_rst   (i_rst),
                .i_en    (ch_en),
                .i_fmt   (ctl0_q[`SAIF_C_FMT_LO + 3*g +: 3]), // R4 R9
                .i_chan  (CH), // R5
                .i_sclk  (i_channel_serial_clock_in[g]),
                .i_fsync (i_channel_frame_sync_in[g]),
                .i_sdata (i_channel_serial_data_in[g]),
                .o_valid (rx_v[g]),
                .o_word  (rx_w[g])
            );

            // Pending word: new arrival wins over grant clear
            always @(posedge i_clk) begin
                if (i_rst) begin
                    pv_q[g] <= 1'b0;
                    pw_q[g] <= 32'h0000_0000;
                end else if (rx_v[g] | own) begin
                    pv_q[g] <= 1'b1; // R1
                    pw_q[g] <= own ? i_par_word : rx_w[g];
                end else if (is_gnt) begin
                    pv_q[g] <= 1'b0;
                end
            end

            // Overflow: set beats a same-cycle clear
            always @(posedge i_clk) begin
                if (i_rst) begin
                    ovf_q[g] <= 1'b0;
                end else if (is_gnt & full) begin
                    ovf_q[g] <= 1'b1; // R21
                end else if (clr_ovf) begin
                    ovf_q[g] <= 1'b0; // R20
                end
            end

            // DMA parameter set: address steps, count falls per word
            always @(posedge i_clk) begin
                if (i_rst) begin
                    dadr_q[g] <= 32'h0000_0000;
                    dcnt_q[g] <= 16'h0000;
                end else begin
                    if (hit_a) begin
                        dadr_q[g] <= i_wdata;
                    end else if (used) begin
                        dadr_q[g] <= dadr_q[g] + 32'h0000_0004; // R18
                    end
                    if (hit_c) begin
                        dcnt_q[g] <= i_wdata[15:0];
                    end else if (used) begin
                        dcnt_q[g] <= dcnt_q[g] - 16'h0001;
                    end
                end
            end
        end
    endgenerate

    // Control registers; the clear bit reads back as zero
    always @(posedge i_clk) begin
        if (i_rst) begin
            ctl0_q <= `SAIF_CTL0_RST;
            chen_q <= 8'h00;
        end else if (i_wr) begin
            if (i_addr == `SAIF_A_CTL0) begin
                ctl0_q <= i_wdata & `SAIF_CTL0_WMSK; // R9 R20
            end
            if (i_addr == `SAIF_A_CHEN) begin
                chen_q <= i_wdata[7:0]; // R19
            end
        end
    end

    // FIFO write side, tag kept beside the word for DMA steering
    always @(posedge i_clk) begin
        if (i_rst) begin
            wp_q <= 3'h0;
        end else if (push) begin
            fw_q[wp_q] <= pw_q[gnt_ch]; // R1
            fc_q[wp_q] <= gnt_ch; // R5
            wp_q       <= wp_q + 3'h1;
        end
    end

    // FIFO read pointer and occupancy
    always @(posedge i_clk) begin
        if (i_rst) begin
            rp_q  <= 3'h0;
            cnt_q <= 4'h0;
        end else begin
            if (pop) begin
                rp_q <= rp_q + 3'h1;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 4'h1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end

    // DMA output stage, held until the sink takes it
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_dma_valid <= 1'b0;
            o_dma_chan  <= 3'h0;
            o_dma_addr  <= 32'h0000_0000;
            o_dma_data  <= 32'h0000_0000;
        end else if (dma_load) begin
            o_dma_valid <= 1'b1;
            o_dma_chan  <= hd_ch; // R5 R18
            o_dma_addr  <= dadr_q[hd_ch];
            o_dma_data  <= fw_q[rp_q];
        end else if (dma_done) begin
            o_dma_valid <= 1'b0;
        end
    end

    // Register read mux, data one cycle after the strobe
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            o_rdata <= 32'h0000_0000;
            if (i_addr == `SAIF_A_CTL0) begin
                o_rdata <= ctl0_q;
            end else if (i_addr == `SAIF_A_CHEN) begin
                o_rdata <= {24'h00_0000, chen_q};
            end else if (i_addr == `SAIF_A_STAT) begin
                o_rdata <= {19'h0_0000, empty, cnt_q, ovf_q};
            end else if (i_addr == `SAIF_A_DATA) begin
                o_rdata <= empty ? 32'h0000_0000 : fw_q[rp_q];
            end else if (i_addr[7:5] == `SAIF_A_DADR) begin
                o_rdata <= dadr_q[i_addr[4:2]];
            end else if (i_addr[7:5] == `SAIF_A_DCNT) begin
                o_rdata <= {16'h0000, dcnt_q[i_addr[4:2]]};
            end
        end
    end
endmodule

// >>> tb/saif_src_model.sv
// Audio source for one channel: clock, sync and data, MSB first.
// Assumes i_data holds still from the rising edge of i_go.
module saif_src_model (
    input  wire logic         i_go,   // Rising edge starts a burst
    input  wire logic         i_i2s,  // I2S framing, else left-justified
    input  wire logic [127:0] i_data, // Two frames, left half first
    output logic              o_sclk, // Serial clock
    output logic              o_fs,   // Frame sync
    output logic              o_sd,   // Serial data
    output logic              o_busy  // Burst running
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [255:0] bits;
    initial begin
        o_sclk = 1'b0;
        o_fs = 1'b0;
        o_sd = 1'b0;
        o_busy = 1'b0;
    end
    // Blank frame each side, since the receiver drops its first half
    always @(posedge i_go) begin
        bits = {{64{1'b0}}, i_data, {64{1'b0}}};
        o_busy = 1'b1;
        #($urandom_range(150, 1));
        for (int b = 0; b < 256; b++) begin
            o_fs = i_i2s ? ((b + 1) % 64 >= 32) : (b % 64 < 32);
            o_sd = bits[255 - b];
            #80 o_sclk = 1'b1;
            #80 o_sclk = 1'b0;
        end
        o_sd = ~o_sd; // Released line shows no stale bit
        o_busy = 1'b0;
    end
endmodule

// >>> tb/saif_top_asserts.sv
// Port-level checks for the serial audio FIFO top.
// Assumes one clock domain and saif_defines.vh on the include path.
`include "saif_defines.vh"
module saif_top_asserts (
    input logic        i_clk,       // Clock
    input logic        i_rst,       // Reset
    input logic [7:0]  i_addr,      // Address
    input logic [31:0] i_wdata,     // Write data
    input logic        i_wr,        // Write
    input logic        i_rd,        // Read
    input logic [31:0] o_rdata,     // Read data
    input logic        o_dma_valid, // DMA offer
    input logic [2:0]  o_dma_chan,  // DMA channel
    input logic [31:0] o_dma_addr,  // DMA address
    input logic [31:0] o_dma_data,  // DMA word
    input logic        i_dma_ready  // DMA accept
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] ctl_q;
    logic [2:0]  dfmt;
    logic [31:0] zm;
    logic        par0;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Shadow control word, so word checks know each channel's format
    always_ff @(posedge i_clk) begin
        if (i_rst) ctl_q <= 32'h0000_0000;
        else if (i_wr && i_addr == `SAIF_A_CTL0) ctl_q <= i_wdata & `SAIF_CTL0_WMSK;
    end
    // Zero-fill field of the offered word's format
    always_comb begin
        dfmt = 3'(ctl_q >> (8 + 3 * o_dma_chan));
        par0 = ctl_q[`SAIF_C_PAR] && o_dma_chan == 3'h0;
        case (dfmt)
            3'h4: zm = 32'h0000_00F0;
            3'h5: zm = 32'h0000_0FF0;
            3'h6: zm = 32'h0000_3FF0;
            3'h7: zm = 32'h0000_FFF0;
            default: zm = 32'h0000_0000;
        endcase
    end
    sequence s_wr_ctl; i_wr && i_addr == `SAIF_A_CTL0; endsequence
    sequence s_rd_ctl; i_rd && i_addr == `SAIF_A_CTL0; endsequence
    property p_ctl_back;
        s_wr_ctl ##1 s_rd_ctl |=> o_rdata == ($past(i_wdata, 2) & `SAIF_CTL0_WMSK);
    endproperty
    property p_clr_low; s_rd_ctl |=> !o_rdata[`SAIF_C_CLROVR]; endproperty
    property p_stat;
        i_rd && i_addr == `SAIF_A_STAT |=> o_rdata[12] == (o_rdata[11:8] == 4'h0)
            && o_rdata[11:8] <= 4'h8;
    endproperty
    property p_hold;
        o_dma_valid && !i_dma_ready |=> o_dma_valid && $stable(o_dma_data)
            && $stable(o_dma_addr) && $stable(o_dma_chan);
    endproperty
    property p_gap; o_dma_valid && i_dma_ready |=> !o_dma_valid; endproperty
    property p_off; !ctl_q[`SAIF_C_DMA] && !o_dma_valid |=> !o_dma_valid; endproperty
    property p_tag;
        o_dma_valid && !par0 && dfmt[2:1] != 2'b01 |-> o_dma_data[2:0] == o_dma_chan;
    endproperty
    property p_fill; o_dma_valid && !par0 |-> (o_dma_data & zm) == 32'h0000_0000; endproperty
    a_ctl_back: assert property (p_ctl_back) else $error("control readback wrong");
    a_clr_low: assert property (p_clr_low) else $error("clear bit read high");
    a_stat: assert property (p_stat) else $error("status count wrong");
    a_hold: assert property (p_hold) else $error("dma word moved");
    a_gap: assert property (p_gap) else $error("dma no gap");
    a_off: assert property (p_off) else $error("dma while off");
    a_tag: assert property (p_tag) else $error("channel tag wrong");
    a_fill: assert property (p_fill) else $error("zero fill wrong");
endmodule
bind saif_top saif_top_asserts saif_top_asserts_inst (.i_clk, .i_rst, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .o_dma_valid, .o_dma_chan, .o_dma_addr, .o_dma_data, .i_dma_ready);

// >>> tb/saif_top_tb_top.sv
// Bench: eight audio sources, register master and stalling DMA sink.
// Assumes the design, checker and source model are compiled first.
module saif_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rdy = 1'b0, pv = 1'b0;
    logic         rd_d = 1'b0;
    logic [7:0]   addr = 8'h00, go = 8'h00, i2s, chen;
    logic [31:0]  wd = 32'h0000_0000, pw = 32'h0000_0000, ctl = 32'h0000_0003, h;
    wire  [7:0]   sck, fs, sd, busy;
    wire  [31:0]  rdata, dad, ddat;
    wire  [2:0]   dch;
    wire          dv;
    logic [127:0] fr [8];
    logic [31:0]  exq [8][$];
    logic [31:0]  rq [$];
    logic [31:0]  pwq [9];
    int           acnt [8] = '{default: 0};
    int           fails = 0, num_checks = 0, w, k;
    saif_top saif_top_inst (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wd),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_channel_serial_clock_in(sck),
        .i_channel_frame_sync_in(fs), .i_channel_serial_data_in(sd), .i_par_valid(pv),
        .i_par_word(pw), .o_dma_valid(dv), .o_dma_chan(dch), .o_dma_addr(dad),
        .o_dma_data(ddat), .i_dma_ready(rdy));
    for (genvar g = 0; g < 8; g++) begin : g_src
        saif_src_model saif_src_model_inst (.i_go(go[g]), .i_i2s(i2s[g]), .i_data(fr[g]),
            .o_sclk(sck[g]), .o_fs(fs[g]), .o_sd(sd[g]), .o_busy(busy[g]));
    end
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, s, e);
        end
    endtask
    task automatic print_verdict();
        if (fails == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One bus cycle; a read notes its expected data
    task automatic bus(input logic wi, input logic ri, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        wr <= wi;
        rd <= ri;
        addr <= a;
        wd <= d;
        if (ri) rq.push_back(d);
    endtask
    function automatic int wid(input int f);
        return (f < 4) ? 32 : (f == 4) ? 24 : (f == 5) ? 20 : (f == 6) ? 18 : 16;
    endfunction
    function automatic logic [31:0] tagw(input int f, input logic [2:0] c, input logic lr,
                                         input logic [31:0] hv);
        if (f == 2 || f == 3) return hv;
        if (f < 2) return {hv[31:4], lr, c};
        return (hv << (32 - wid(f))) | {28'h000_0000, lr, c};
    endfunction
    function automatic int pend();
        int n = 0;
        foreach (exq[i]) n += exq[i].size();
        return n;
    endfunction
    // Read data looked at only in the cycle after the strobe
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) chk(rdata, rq.pop_front());
    end
    // DMA sink with random stalls; blank halves are skipped
    always @(posedge clk) begin
        rdy <= ($urandom % 4) != 0;
        if (dv === 1'b1 && rdy === 1'b1) begin
            chk(dad, {17'h0, dch, 12'h000} + 32'(acnt[dch] * 4));
            acnt[dch]++;
            if (ddat[31:4] !== 28'h000_0000) chk(ddat, exq[dch].pop_front());
        end
    end
    // Hang guard, well past the expected run
    initial begin
        #200000;
        fails++;
        print_verdict();
    end
    initial begin
        void'($urandom(47));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        bus(0, 1, 8'h00, 32'h0000_0000);
        bus(0, 1, 8'h08, 32'h0000_1000);
        bus(0, 1, 8'h24, 32'h0000_0000);
        bus(1, 0, 8'h00, 32'hFFFF_FFFF);
        bus(0, 1, 8'h00, 32'hFFFF_FF0B);
        for (k = 0; k < 8; k++) begin
            bus(1, 0, 8'(8'h40 + 4 * k), 32'(k) << 12);
            bus(1, 0, 8'(8'h60 + 4 * k), 32'h0000_FFFF);
            ctl[8 + 3 * k +: 3] = 3'(k);
            i2s[k] = (k == 0 || k == 2);
        end
        // Pass 0 leaves channel 7 disabled, pass 1 enables all
        for (int p = 0; p < 2; p++) begin
            chen = p ? 8'hFF : 8'h7F;
            for (k = 0; k < 32; k++) begin
                w = wid(k / 4);
                h = $urandom;
                h[w - 1] = 1'b1;
                fr[k / 4][127 - 32 * (k % 4) -: 32] = h;
                if (chen[k / 4]) exq[k / 4].push_back(tagw(k / 4, 3'(k / 4), k % 2 == 0, h));
            end
            bus(1, 0, 8'h04, {24'h00_0000, chen});
            bus(1, 0, 8'h00, ctl);
            bus(0, 0, 8'h00, 32'h0000_0000);
            go <= 8'hFF;
            repeat (4) @(posedge clk);
            go <= 8'h00;
            for (k = 0; k < 12000 && busy != 8'h00; k++) @(posedge clk);
            chk(32'(busy), 32'h0000_0000);
            for (k = 0; k < 400 && pend() != 0; k++) @(posedge clk);
            for (k = 0; k < 8; k++) chk(32'(exq[k].size()), 32'h0000_0000);
        end
        // Parameter sets must have stepped once per word the sink took
        bus(0, 1, 8'h40, 32'(acnt[0]) << 2);
        bus(0, 1, 8'h64, 32'h0000_FFFF - 32'(acnt[1]));
        bus(1, 0, 8'h00, 32'h0000_0009);
        bus(0, 0, 8'h00, 32'h0000_0000);
        for (k = 0; k < 9; k++) begin
            pwq[k] = $urandom | 32'h8000_0000;
            @(posedge clk);
            pv <= 1'b1;
            pw <= pwq[k];
            @(posedge clk);
            pv <= 1'b0;
            repeat (10) @(posedge clk);
        end
        bus(0, 1, 8'h08, 32'h0000_0801);
        for (k = 0; k < 8; k++) bus(0, 1, 8'h0C, pwq[k]);
        bus(0, 1, 8'h08, 32'h0000_1001);
        bus(1, 0, 8'h00, 32'h0000_000D);
        bus(0, 1, 8'h08, 32'h0000_1000);
        bus(0, 1, 8'h0C, 32'h0000_0000);
        bus(0, 0, 8'h00, 32'h0000_0000);
        repeat (3) @(posedge clk);
        print_verdict();
    end
endmodule
